// ---- include/pew_pkg.sv ----
// Constants for the host-side parallel EEPROM write controller.
// Assumes a 100 MHz system clock and a byte-wide asynchronous EEPROM on the pins.
// Operation
// - Write starts on strobe low pulse with select low and gate high.
// - Host sends each next page byte within 150 us of the previous.
// - Host keeps page select bits constant across a page load; the controller sends each request's address unchecked.
// - Three command writes enable protection after one write cycle time.
// - Protected writes are preceded by the same three-write sequence.
// - Command bytes follow page timing and are not stored.
// - High voltage on address bit nine reaches the 64-byte ID area.
package pew_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int BYTE_IN_PAGE_W = 6;
  localparam int POLL_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  // Strobe low and pulse high widths, ns
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_HIGH_NS = 50;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  // Read access time, ns
  localparam int READ_ACC_NS = 120;
  localparam int READ_ACC_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
  // Byte load interval, us (longest, no rounding)
  localparam int BYTE_LOAD_US = 150;
  localparam int BYTE_LOAD_CYC = BYTE_LOAD_US * CLK_MHZ;
  // Write cycle time, ms
  localparam int WRITE_CYCLE_MS = 10;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  // Power-on delay, ms
  localparam int POWER_ON_MS = 5;
  localparam int POWER_ON_CYC = POWER_ON_MS * 1000 * CLK_MHZ;
  // Protection command sequence defaults (arbitrary)
  localparam logic [14:0] CMD_ADDR0 = 15'h0aaa;
  localparam logic [14:0] CMD_ADDR1 = 15'h0555;
  localparam logic [7:0] CMD_DATA0 = 8'h5a;
  localparam logic [7:0] CMD_DATA1 = 8'ha5;
  localparam logic [7:0] CMD_DATA_EN = 8'h3c;
  localparam logic [7:0] CMD_DATA_DIS = 8'hc3;
  localparam logic [14:0] ID_AREA_BASE = 15'h7fc0;
  localparam int CNT_W = 32;
endpackage

// ---- logic/pew_host.sv ----
// Host controller that runs reads, page writes, protection commands and end-of-write polling on the EEPROM pins.
// Assumes pins are registered here and the device inputs are synchronous to i_clk.
`timescale 1ns/1ps
module pew_host
  import pew_pkg::*;
#(
  parameter int POWER_ON_CYCLES = POWER_ON_CYC,
  parameter int WRITE_CYCLE_CYCLES = WRITE_CYCLE_CYC,
  parameter int BYTE_LOAD_CYCLES = BYTE_LOAD_CYC,
  parameter logic [14:0] CMD_A0 = CMD_ADDR0,
  parameter logic [14:0] CMD_A1 = CMD_ADDR1,
  parameter logic [7:0] CMD_D0 = CMD_DATA0,
  parameter logic [7:0] CMD_D1 = CMD_DATA1,
  parameter logic [7:0] CMD_DEN = CMD_DATA_EN,
  parameter logic [7:0] CMD_DDIS = CMD_DATA_DIS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_last,
  input wire logic i_req_protected,
  input wire logic i_req_id_area,
  input wire logic [1:0] i_req_cmd,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_data,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_wr_done,
  output logic o_wr_timeout,
  output logic o_power_ok,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_id_area_select_pin,
  output logic o_mem_chip_sel_n,
  output logic o_mem_out_gate_n,
  output logic o_mem_wr_strobe_n,
  output logic [DATA_W-1:0] o_mem_data,
  output logic o_mem_data_oe_n,
  input wire logic [DATA_W-1:0] i_mem_data
);
  typedef enum logic [3:0] {
    S_POWER, S_IDLE, S_RD_WAIT, S_WR_LOW, S_WR_HIGH, S_LOAD_GAP, S_POLL_RD, S_POLL_GAP
  } pew_state_t;

  typedef struct packed {
    pew_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wc_cnt;
    logic [1:0] cmd_idx;
    logic [1:0] cmd_kind;
    logic data_last;
    logic pend;
    logic pend_last;
    logic pend_id;
    logic [DATA_W-1:0] last_data;
    logic [ADDR_W-1:0] last_addr;
    logic have_prev;
    logic prev_toggle;
    logic power_ok;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic wr_done;
    logic wr_timeout;
    logic [ADDR_W-1:0] addr;
    logic id_sel;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] dout;
    logic dout_oe_n;
  } pew_reg_t;

  pew_reg_t s_r;
  pew_reg_t s_nxt;
  logic byte_load_rd;

  assign byte_load_rd = (s_r.cnt >= CNT_W'(BYTE_LOAD_CYCLES - STROBE_HIGH_CYC - 2));

  // Next-state logic for pin sequencing and polling
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.wr_done = 1'b0;
    s_nxt.wr_timeout = 1'b0;
    o_req_ready = 1'b0;
    unique case (s_r.st)
      S_POWER: begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.cnt >= CNT_W'(POWER_ON_CYCLES - 1)) begin
          s_nxt.power_ok = 1'b1;
          s_nxt.st = S_IDLE;
          s_nxt.cnt = '0;
        end
      end
      S_IDLE, S_LOAD_GAP: begin
        o_req_ready = (s_r.cmd_idx == 2'd0) || (s_r.st == S_IDLE);
        if (s_r.st == S_LOAD_GAP) begin
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
        if (s_r.st == S_LOAD_GAP && s_r.cmd_idx != 2'd0) begin
          // Command sequence bytes back to back
          o_req_ready = 1'b0;
          s_nxt.addr = (s_r.cmd_idx == 2'd1) ? CMD_A1 : CMD_A0;
          s_nxt.dout = (s_r.cmd_idx == 2'd1) ? CMD_D1 :
            ((s_r.cmd_kind == 2'd2) ? CMD_DDIS : CMD_DEN);
          s_nxt.cmd_idx = s_r.cmd_idx + 2'd1;
          s_nxt.data_last = (s_r.cmd_idx == 2'd2) && (s_r.cmd_kind != 2'd1);
          s_nxt.id_sel = 1'b0;
          s_nxt.st = S_WR_LOW;
          s_nxt.cnt = '0;
        end else if (s_r.st == S_LOAD_GAP && s_r.pend) begin
          // Held data byte of a protected write goes out right after its prefix
          o_req_ready = 1'b0;
          s_nxt.addr = s_r.last_addr;
          s_nxt.dout = s_r.last_data;
          s_nxt.data_last = s_r.pend_last;
          s_nxt.id_sel = s_r.pend_id;
          s_nxt.pend = 1'b0;
          s_nxt.st = S_WR_LOW;
          s_nxt.cnt = '0;
        end else if (s_r.st == S_LOAD_GAP && s_r.data_last) begin
          o_req_ready = 1'b0; // Load closed, nothing more taken
          s_nxt.st = S_POLL_GAP;
          s_nxt.wc_cnt = '0;
          s_nxt.have_prev = 1'b0;
          s_nxt.cnt = '0;
        end else if (s_r.st == S_LOAD_GAP && byte_load_rd) begin
          o_req_ready = 1'b0; // Load closed, nothing more taken
          s_nxt.wr_timeout = 1'b1;
          s_nxt.st = S_POLL_GAP;
          s_nxt.wc_cnt = '0;
          s_nxt.have_prev = 1'b0;
          s_nxt.cnt = '0;
        end else if (i_req_valid) begin
          s_nxt.addr = i_req_addr;
          s_nxt.id_sel = i_req_id_area;
          s_nxt.cnt = '0;
          s_nxt.cs_n = 1'b0;
          if (!i_req_write && s_r.st == S_IDLE) begin
            s_nxt.oe_n = 1'b0;
            s_nxt.st = S_RD_WAIT;
          end else if (i_req_write && i_req_cmd != 2'd0 && s_r.st == S_IDLE) begin
            // Protection command: enable, disable, or enable-prefixed data load
            s_nxt.cmd_kind = i_req_cmd;
            s_nxt.addr = CMD_A0;
            s_nxt.dout = CMD_D0;
            s_nxt.cmd_idx = 2'd1;
            s_nxt.data_last = 1'b0;
            s_nxt.id_sel = 1'b0;
            s_nxt.st = S_WR_LOW;
          end else if (i_req_write) begin
            s_nxt.dout = i_req_data;
            s_nxt.data_last = i_req_last;
            s_nxt.last_data = i_req_data;
            s_nxt.last_addr = i_req_addr;
            if (i_req_protected && s_r.st == S_IDLE) begin
              s_nxt.cmd_kind = 2'd1;
              s_nxt.pend = 1'b1;
              s_nxt.pend_last = i_req_last;
              s_nxt.pend_id = i_req_id_area;
              s_nxt.addr = CMD_A0;
              s_nxt.dout = CMD_D0;
              s_nxt.cmd_idx = 2'd1;
              s_nxt.data_last = 1'b0;
              s_nxt.id_sel = 1'b0;
            end
            s_nxt.st = S_WR_LOW;
          end else begin
            // Reads refused during a page load; pins and load timer left alone
            s_nxt.addr = s_r.addr;
            s_nxt.id_sel = s_r.id_sel;
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
            s_nxt.cs_n = 1'b1;
            o_req_ready = 1'b0;
          end
        end
      end
      S_RD_WAIT: begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.cnt >= CNT_W'(READ_ACC_CYC - 1)) begin
          s_nxt.rd_data = i_mem_data;
          s_nxt.rd_valid = 1'b1;
          s_nxt.cs_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st = S_IDLE;
        end
      end
      S_WR_LOW: begin
        // Gate held high, data driven, strobe low long enough to pass the noise filter
        s_nxt.cs_n = 1'b0;
        s_nxt.oe_n = 1'b1;
        s_nxt.we_n = 1'b0;
        s_nxt.dout_oe_n = 1'b0;
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.cnt >= CNT_W'(STROBE_LOW_CYC)) begin
          s_nxt.we_n = 1'b1;
          s_nxt.st = S_WR_HIGH;
          s_nxt.cnt = '0;
        end
      end
      S_WR_HIGH: begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.cnt >= CNT_W'(STROBE_HIGH_CYC - 1)) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.dout_oe_n = 1'b1;
          s_nxt.st = S_LOAD_GAP;
          s_nxt.cnt = '0;
          if (s_r.cmd_idx == 2'd3) begin
            s_nxt.cmd_idx = 2'd0;
            if (s_r.cmd_kind == 2'd1) begin
              // Data bytes of a protected load follow; page select held by caller
              s_nxt.data_last = 1'b0;
            end
          end
        end
      end
      S_POLL_GAP: begin
        s_nxt.wc_cnt = s_r.wc_cnt + CNT_W'(1);
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        s_nxt.addr = s_r.last_addr;
        if (s_r.wc_cnt >= CNT_W'(WRITE_CYCLE_CYCLES)) begin
          s_nxt.wr_timeout = 1'b1;
          s_nxt.wr_done = 1'b1;
          s_nxt.cmd_kind = 2'd0;
          s_nxt.st = S_IDLE;
        end else if (s_r.cnt >= CNT_W'(STROBE_HIGH_CYC)) begin
          s_nxt.cs_n = 1'b0;
          s_nxt.oe_n = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.st = S_POLL_RD;
        end
      end
      S_POLL_RD: begin
        s_nxt.wc_cnt = s_r.wc_cnt + CNT_W'(1);
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.cnt >= CNT_W'(READ_ACC_CYC - 1)) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.have_prev = 1'b1;
          s_nxt.prev_toggle = i_mem_data[TOGGLE_STATUS_BIT];
          s_nxt.st = S_POLL_GAP;
          // Done when polling bit true and toggle bit steady; command-only writes need only the toggle bit steady
          if ((s_r.cmd_kind == 2'd0 || s_r.cmd_kind == 2'd1) &&
              i_mem_data[POLL_STATUS_BIT] == s_r.last_data[POLL_STATUS_BIT] &&
              s_r.have_prev && i_mem_data[TOGGLE_STATUS_BIT] == s_r.prev_toggle) begin
            s_nxt.wr_done = 1'b1;
            s_nxt.cmd_kind = 2'd0;
            s_nxt.st = S_IDLE;
          end else if (s_r.cmd_kind[1] && s_r.have_prev &&
              i_mem_data[TOGGLE_STATUS_BIT] == s_r.prev_toggle) begin
            s_nxt.wr_done = 1'b1;
            s_nxt.cmd_kind = 2'd0;
            s_nxt.st = S_IDLE;
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{st: S_POWER, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dout_oe_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rd_valid = s_r.rd_valid;
  assign o_rd_data = s_r.rd_data;
  assign o_wr_done = s_r.wr_done;
  assign o_wr_timeout = s_r.wr_timeout;
  assign o_power_ok = s_r.power_ok;
  assign o_mem_addr = s_r.addr;
  assign o_id_area_select_pin = s_r.id_sel;
  assign o_mem_chip_sel_n = s_r.cs_n;
  assign o_mem_out_gate_n = s_r.oe_n;
  assign o_mem_wr_strobe_n = s_r.we_n;
  assign o_mem_data = s_r.dout;
  assign o_mem_data_oe_n = s_r.dout_oe_n;
endmodule

// ---- test/pew_host_asserts.sv ----
// Checker for the pin sequencing of the host EEPROM controller.
// Bound to pew_host; sees its ports only.
`timescale 1ns/1ps
module pew_host_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  input wire logic o_power_ok,
  input wire logic [14:0] o_mem_addr,
  input wire logic [7:0] o_mem_data,
  input wire logic o_id_area_select_pin,
  input wire logic o_mem_chip_sel_n,
  input wire logic o_mem_out_gate_n,
  input wire logic o_mem_wr_strobe_n,
  input wire logic o_mem_data_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Write strobe framing, bus ownership, read latency, ID area address range and no access before power-on
  a_strobe_gate_high: assert property (!o_mem_wr_strobe_n |-> o_mem_out_gate_n && !o_mem_chip_sel_n)
    else $error("strobe low with gate low or select high");
  a_strobe_drives_data: assert property (!o_mem_wr_strobe_n |-> !o_mem_data_oe_n)
    else $error("strobe low without data driven");
  a_read_no_drive: assert property (!o_mem_out_gate_n |-> o_mem_data_oe_n)
    else $error("host drives data while gate low");
  a_strobe_width: assert property ($fell(o_mem_wr_strobe_n) |-> !o_mem_wr_strobe_n[*8] ##1 !o_mem_wr_strobe_n[*2])
    else $error("write strobe pulse too short");
  a_addr_data_held: assert property (!o_mem_wr_strobe_n && !$past(o_mem_wr_strobe_n)
    |-> $stable(o_mem_addr) && $stable(o_mem_data))
    else $error("address or data moved during strobe");
  a_read_latency: assert property (i_req_valid && o_req_ready && !i_req_write |-> ##13 o_rd_valid)
    else $error("read data not returned on time");
  a_id_area_addr: assert property (o_id_area_select_pin && !o_mem_chip_sel_n
    |-> o_mem_addr[14:6] == 9'h1ff)
    else $error("id area access outside top 64 addresses");
  a_no_early_write: assert property (!o_power_ok |-> o_mem_chip_sel_n && o_mem_wr_strobe_n)
    else $error("device accessed before power on delay");
  // Main scenarios reached
  c_write: cover property ($fell(o_mem_wr_strobe_n));
  c_read: cover property (o_rd_valid);
  c_id_write: cover property (o_id_area_select_pin && !o_mem_wr_strobe_n);
endmodule
bind pew_host pew_host_asserts pew_host_asserts_inst (.i_clk, .i_rst_n, .i_req_valid, .i_req_write,
  .o_req_ready, .o_rd_valid, .o_power_ok, .o_mem_addr, .o_mem_data, .o_id_area_select_pin,
  .o_mem_chip_sel_n, .o_mem_out_gate_n, .o_mem_wr_strobe_n, .o_mem_data_oe_n);

// ---- test/pew_eeprom_model.sv ----
// Behavioural byte-wide EEPROM for the host controller bench.
// Timers count bench clock cycles; the data bus is resolved here.
`timescale 1ns/1ps
module pew_eeprom_model
  import pew_pkg::*;
#(
  parameter int PON = 150,
  parameter int BLC = 400,
  parameter int WC = 600
) (
  input wire logic i_clk,
  input wire logic [14:0] i_addr,
  input wire logic i_id,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_hd,
  input wire logic i_hoe_n,
  output logic [7:0] o_bus
);
  logic [7:0] mem [0:32767];
  logic [7:0] idm [0:63];
  logic [14:0] la [0:66];
  logic [7:0] ld [0:66];
  logic [14:0] wa;
  logic [7:0] lastd = 0, lastv = 0;
  logic prot = 0, tog = 0, rdq = 0, idl = 0, cmd = 0, blk = 0;
  int nb = 0, blc = 0, busy = 0, pon = 0;
  realtime t0 = 0;
  wire rd = !i_cs_n && !i_oe_n && i_we_n;
  wire wr = !i_cs_n && !i_we_n && i_oe_n;
  // Blank array
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (idm[i]) idm[i] = 8'hff;
  end
  // Read path, poll form while busy, else host data or a moving float
  assign o_bus = rd ? (busy > 0 ? {~lastd[7], tog, lastd[5:0]} : i_id ? idm[i_addr[5:0]] : mem[i_addr])
    : !i_hoe_n ? i_hd : ~lastv;
  // Address on the later falling edge
  always @(posedge wr) begin
    t0 = $realtime;
    wa = i_addr;
  end
  // Data on the first rising edge, short pulses dropped
  always @(negedge wr) begin
    if ($realtime - t0 >= 15.0 && pon >= PON && busy == 0 && nb < 67) begin
      la[nb] = wa;
      ld[nb] = i_hd;
      idl = i_id;
      nb++;
      blc = 0;
    end
  end
  // Load interval, write timer, toggle bit and protection state
  always @(posedge i_clk) begin
    lastv <= o_bus;
    if (pon < PON) pon++;
    if (rdq && !rd && busy > 0) tog = !tog;
    rdq = rd;
    if (busy == 0 && nb > 0 && (++blc > BLC || rd)) begin
      cmd = nb >= 3 && la[0] == CMD_ADDR0 && ld[0] == CMD_DATA0 && la[1] == CMD_ADDR1 && ld[1] == CMD_DATA1
        && (ld[2] == CMD_DATA_EN || ld[2] == CMD_DATA_DIS);
      blk = prot && !cmd;
      lastd = ld[nb-1];
      busy = WC;
    end else if (busy > 0 && --busy == 0) begin
      for (int i = cmd ? 3 : 0; i < nb; i++) begin
        if (!blk && idl) idm[la[i][5:0]] = ld[i];
        else if (!blk) mem[la[i]] = ld[i];
      end
      if (cmd) prot = ld[2] == CMD_DATA_EN;
      nb = 0;
    end
  end
endmodule

// ---- test/pew_host_tb.sv ----
// Self-checking bench for pew_host driving a behavioural EEPROM.
// Power-on, byte load and write cycle counts are shortened.
`timescale 1ns/1ps
module pew_host_tb;
  import pew_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0, i_req_last = 0;
  logic i_req_protected = 0, i_req_id_area = 0, dn, to;
  logic [1:0] i_req_cmd = 0;
  logic [14:0] i_req_addr = 0, o_mem_addr;
  logic [7:0] i_req_data = 0, i_mem_data, o_rd_data, o_mem_data;
  logic o_req_ready, o_rd_valid, o_wr_done, o_wr_timeout, o_power_ok, o_id_area_select_pin;
  logic o_mem_chip_sel_n, o_mem_out_gate_n, o_mem_wr_strobe_n, o_mem_data_oe_n;
  int n_errors = 0, tests_run = 0;
  // Bench clock
  always #5 i_clk = ~i_clk;
  pew_host #(.POWER_ON_CYCLES(200), .WRITE_CYCLE_CYCLES(2000), .BYTE_LOAD_CYCLES(400)) pew_host_inst (.*);
  pew_eeprom_model pew_eeprom_model_inst (.i_clk(i_clk),
    .i_addr(o_mem_addr), .i_id(o_id_area_select_pin), .i_cs_n(o_mem_chip_sel_n), .i_oe_n(o_mem_out_gate_n),
    .i_we_n(o_mem_wr_strobe_n), .i_hd(o_mem_data), .i_hoe_n(o_mem_data_oe_n), .o_bus(i_mem_data));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_byte(string nm, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(string nm, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // One request, held until taken
  task automatic req(logic w, logic l, logic [1:0] c, logic p, logic id, logic [14:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_req_valid <= 1;
    i_req_write <= w;
    i_req_last <= l;
    i_req_cmd <= c;
    i_req_protected <= p;
    i_req_id_area <= id;
    i_req_addr <= a;
    i_req_data <= d;
    do @(posedge i_clk); while (o_req_ready !== 1'b1);
    i_req_valid <= 0;
  endtask
  task automatic wait_wr;
    dn = 0;
    to = 0;
    repeat (3000) begin
      @(posedge i_clk);
      #1;
      dn = o_wr_done;
      to = o_wr_timeout;
      if (dn === 1'b1 || to === 1'b1) break;
    end
  endtask
  task automatic wr1(logic [1:0] c, logic p, logic id, logic [14:0] a, logic [7:0] d);
    req(1, 1, c, p, id, a, d);
    wait_wr;
  endtask
  task automatic chk_rd(logic id, logic [14:0] a, logic [7:0] exp);
    logic [7:0] d;
    d = 'x;
    req(0, 0, 0, 0, id, a, 0);
    repeat (40) begin
      @(posedge i_clk);
      #1;
      if (o_rd_valid === 1'b1) begin
        d = o_rd_data;
        break;
      end
    end
    chk_byte($sformatf("read %h", a), exp, d);
  endtask
  task automatic t_power;
    repeat (190) @(posedge i_clk);
    #1 chk_bit("power_ok early", 0, o_power_ok);
    repeat (20) @(posedge i_clk);
    chk_bit("power_ok", 1, o_power_ok);
  endtask
  task automatic t_byte;
    wr1(0, 0, 0, 15'h0123, 8'h81);
    chk_bit("byte done", 1, dn);
    chk_rd(0, 15'h0123, 8'h81);
  endtask
  task automatic t_page;
    req(1, 0, 0, 0, 0, 15'h0245, 8'h11);
    req(1, 0, 0, 0, 0, 15'h0241, 8'h22);
    wr1(0, 0, 0, 15'h0245, 8'h33);
    chk_rd(0, 15'h0245, 8'h33);
    chk_rd(0, 15'h0241, 8'h22);
    chk_rd(0, 15'h0242, 8'hff);
  endtask
  task automatic t_timeout;
    req(1, 0, 0, 0, 0, 15'h0300, 8'h44);
    wait_wr;
    chk_bit("load timeout", 1, to);
    repeat (800) @(posedge i_clk);
    chk_rd(0, 15'h0300, 8'h44);
  endtask
  task automatic t_prot;
    req(1, 0, 1, 0, 0, 15'h0400, 8'h00);
    wr1(0, 0, 0, 15'h0400, 8'h55);
    chk_rd(0, 15'h0400, 8'h55);
    chk_rd(0, CMD_ADDR0, 8'hff);
    wr1(3, 0, 0, 15'h0500, 8'h00);
    wr1(0, 0, 0, 15'h0401, 8'h66);
    chk_rd(0, 15'h0401, 8'hff);
    wr1(0, 1, 0, 15'h0402, 8'h77);
    chk_rd(0, 15'h0402, 8'h77);
    wr1(2, 0, 0, 15'h0500, 8'h00);
    wr1(0, 0, 0, 15'h0401, 8'h66);
    chk_rd(0, 15'h0401, 8'h66);
  endtask
  task automatic t_id;
    wr1(0, 0, 1, 15'h7fc5, 8'h9a);
    chk_rd(1, 15'h7fc5, 8'h9a);
    chk_rd(0, 15'h7fc5, 8'hff);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    t_power;
    t_byte;
    t_page;
    t_timeout;
    t_prot;
    t_id;
    end_sim;
  end
  // Hang guard, several times the expected run
  initial begin
    #600000;
    n_errors++;
    end_sim;
  end
endmodule
